// ---- core/hb_toggle_timer.sv ----
// reloading down-counter that toggles the high-band tone on underflow
`timescale 1ns/1ns
`default_nettype none
module hb_toggle_timer
    import tone_pkg::*;
#(
    parameter int W = 8       // counter and reload width
) (
    input  wire logic         clock,
    input  wire logic         rstn,
    input  wire logic         preset,     // burst start: preset count, tone low
    input  wire logic         clear,      // burst end: force tone low
    input  wire logic         run,        // counter running
    input  wire logic         toggleEn,   // output enabled
    input  wire logic [W-1:0] reloadVal,  // half period minus one
    output logic              toneOut,
    output logic [W-1:0]      count
);
    logic [W-1:0] count_r;    // down-counter
    logic [W-1:0] count_nxt;
    logic         tone_r;     // high-band output level
    logic         tone_nxt;

    // next count and tone; preset and clear outrank the running counter
    always_comb begin
        count_nxt = count_r;
        tone_nxt  = tone_r;
        if (preset) begin
            count_nxt = W'(HB_PRESET);                      // [R15]
            tone_nxt  = 1'b0;
        end else if (clear) begin
            tone_nxt  = 1'b0;
        end else if (run) begin
            if (count_r == '0) begin
                // underflow: reload in the same cycle, so half period is reload+1
                count_nxt = reloadVal;                      // [R13] [R14]
                if (toggleEn) begin
                    tone_nxt = ~tone_r;                     // [R14]
                end
            end else begin
                count_nxt = count_r - 1'b1;
            end
        end
    end

    // register stage
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            count_r <= '0;
            tone_r  <= 1'b0;
        end else begin
            count_r <= count_nxt;
            tone_r  <= tone_nxt;
        end
    end

    assign toneOut = tone_r;
    assign count   = count_r;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    chk_hb_underflow: assert property (  // [R14]
        (run && !preset && !clear && count_r == '0)
            |=> (count_r == $past(reloadVal)) && (tone_r == ($past(tone_r) ^ $past(toggleEn))))
        else $error("high-band underflow did not reload and toggle");

    chk_hb_preset: assert property (  // [R15]
        preset |=> (count_r == HB_PRESET[W-1:0]) && !tone_r)
        else $error("high-band counter not preset to 15");
endmodule
`default_nettype wire

// ---- core/square_tone_routine.sv ----
// dual-tone square-wave burst generator with parameter table and register port
//
// Notes on behaviour
// R01 - key code is 1001RRCC: row 3:2, column 1:0
// R02 - indices: 0011CC00 timer, 0011RR11/10/01 low band
// R03 - sixteen byte entries at indices 0x30..0x3f
// R04 - column picks timer; row picks three parameters
// R05 - half period expiry inverts low tone, reloads
// R06 - quotient drops per half period; zero enters remainder
// R07 - remainder expiry drives both tones low, ends
// R08 - burst lasts about 35796 clock cycles
// R09 - half and remainder counted in six-cycle units
// R10 - low half periods 257/232/210/190, toggle-independent
// R11 - stored quotient is true count plus one
// R12 - remainder phase adds twenty overhead cycles
// R13 - timer reload is high half period minus one
// R14 - underflow inverts high tone and reloads
// R15 - high counter preset to 15 at start
// R16 - controller writes 0xb0 to control at 0xff
// R17 - upper bits not 1001 flag error, no tones
// R18 - fetch half, quotient, remainder by decrementing index
// R19 - keypad nibbles E, D, B, 7 mean one key
// R20 - start pulse begins; busy, then done pulse
//
// Chosen here: the address map and strobed register access.
`timescale 1ns/1ns
`default_nettype none
module square_tone_routine
    import tone_pkg::*;
#(
    parameter int TW = 8      // high-band timer width
) (
    input  wire logic       clock,
    input  wire logic       rstn,
    input  wire logic       startPulse,   // one-cycle burst request
    input  wire logic [7:0] keyMatrix,    // digit matrix vector 1001RRCC
    input  wire logic [7:0] regAddr,      // register address
    input  wire logic [7:0] regWrData,    // register write data
    input  wire logic       regWrStrobe,  // one-cycle write
    input  wire logic       regRdStrobe,  // one-cycle read
    output logic [7:0]      regRdData,    // valid the cycle after a read
    output logic            lowToneOut,   // low-band square wave
    output logic            highToneOut,  // high-band square wave
    output logic            busy,         // burst in progress
    output logic            done,         // one-cycle end of operation
    output logic            keyError      // last request taken while idle had no single key
);
    state_t       state_r, state_nxt;         // burst controller
    tone_params_t par_r, par_nxt;             // low-band parameters in cycles
    logic [7:0]   fetchIdx_r, fetchIdx_nxt;   // current table index
    logic [1:0]   fetchNum_r, fetchNum_nxt;   // which parameter is fetched
    logic [1:0]   row_r, row_nxt;             // latched row select
    logic [9:0]   halfCnt_r, halfCnt_nxt;     // low-band cycle counter
    logic [9:0]   remCnt_r, remCnt_nxt;       // remainder cycle counter
    logic         newHalf_r, newHalf_nxt;     // first cycle of a half period
    logic         lowTone_r, lowTone_nxt;     // low-band level
    logic         err_r, err_nxt;             // sticky key error
    logic [7:0]   ctrl_r, ctrl_nxt;           // timer_ctrl_reg
    logic [TW-1:0] reload_r, reload_nxt;      // high-band reload value
    logic [7:0]   rdData_r, rdData_nxt;       // registered read data
    logic         hbPreset, hbClear;          // timer controls from the sequencer
    logic [TW-1:0] hbCount;                   // timer count, checked by assertion only
    logic         highTone;                   // timer output
    logic [7:0]   tableData;                  // entry at fetchIdx_r
    logic [1:0]   keyRow, keyCol;             // fields of the key code

    // stall units to cycles: (n - 1) * 6 + overhead
    function automatic logic [9:0] unitsToCycles(input logic [7:0] n, input logic [5:0] ovh);
        logic [9:0] m;
        m = {2'b00, n} - 10'h001;
        return (m << 2) + (m << 1) + {4'h0, ovh};              // [R09]
    endfunction

    // index 0x30..0x3f maps onto the table; only the low nibble selects
    function automatic logic [7:0] tableRead(input logic [7:0] idx);
        return PARAM_TABLE[idx[3:0]];                          // [R03]
    endfunction

    assign keyRow    = keyMatrix[3:2];                         // [R01]
    assign keyCol    = keyMatrix[1:0];                         // [R01]
    assign tableData = tableRead(fetchIdx_r);

    // burst sequencer: next state, counters and tone level
    always_comb begin
        state_nxt    = state_r;
        par_nxt      = par_r;
        fetchIdx_nxt = fetchIdx_r;
        fetchNum_nxt = fetchNum_r;
        row_nxt      = row_r;
        halfCnt_nxt  = halfCnt_r;
        remCnt_nxt   = remCnt_r;
        newHalf_nxt  = 1'b0;
        lowTone_nxt  = lowTone_r;
        err_nxt      = err_r;
        reload_nxt   = reload_r;
        hbPreset     = 1'b0;
        hbClear      = 1'b0;
        case (state_r)
            ST_IDLE: begin
                if (startPulse) begin
                    if (keyMatrix[7:4] != KEY_VALID) begin
                        // no key or several keys: flag and end without tones
                        err_nxt   = 1'b1;                      // [R17]
                        state_nxt = ST_DONE;
                    end else begin
                        err_nxt      = 1'b0;
                        row_nxt      = keyRow;
                        // column picks only the timer reload
                        reload_nxt   = TW'(tableRead({VEC_PREFIX, keyCol, SUB_TIMER})); // [R02] [R04] [R13]
                        fetchIdx_nxt = {VEC_PREFIX, keyRow, SUB_HALF}; // [R02] [R04]
                        fetchNum_nxt = 2'd0;
                        state_nxt    = ST_FETCH;
                    end
                end
            end
            ST_FETCH: begin
                // one entry per cycle, index walks down F -> Q -> R
                case (fetchNum_r)
                    2'd0: par_nxt.halfTotal = unitsToCycles(tableData, HALF_OVERHEAD[row_r]); // [R10] [R18]
                    2'd1: par_nxt.quot = tableData;                // [R11] [R18]
                    default: par_nxt.remTotal = unitsToCycles(tableData, REM_OVERHEAD); // [R12] [R18]
                endcase
                fetchIdx_nxt = fetchIdx_r - 8'h01;             // [R18]
                fetchNum_nxt = fetchNum_r + 2'd1;
                if (fetchNum_r == 2'd2) begin
                    state_nxt   = ST_HALF;
                    halfCnt_nxt = par_r.halfTotal - 10'h001;
                    newHalf_nxt = 1'b1;
                    lowTone_nxt = 1'b0;
                    hbPreset    = 1'b1;                        // [R15]
                end
            end
            ST_HALF: begin
                if (newHalf_r && par_r.quot == 8'h01) begin
                    // zero test comes early, hence the stored extra count
                    par_nxt.quot = 8'h00;                      // [R06] [R11]
                    state_nxt    = ST_REM;
                    remCnt_nxt   = par_r.remTotal - 10'h001;
                end else begin
                    if (newHalf_r) begin
                        par_nxt.quot = par_r.quot - 8'h01;     // [R06]
                    end
                    if (halfCnt_r == 10'h000) begin
                        // same length whether setting or clearing the output
                        lowTone_nxt = ~lowTone_r;              // [R05] [R10]
                        halfCnt_nxt = par_r.halfTotal - 10'h001; // [R05]
                        newHalf_nxt = 1'b1;
                    end else begin
                        halfCnt_nxt = halfCnt_r - 10'h001;
                    end
                end
            end
            ST_REM: begin
                if (remCnt_r == 10'h000) begin
                    lowTone_nxt = 1'b0;                        // [R07]
                    hbClear     = 1'b1;                        // [R07]
                    state_nxt   = ST_DONE;                     // [R08]
                end else begin
                    remCnt_nxt = remCnt_r - 10'h001;
                end
            end
            ST_DONE: begin
                state_nxt = ST_IDLE;                           // [R20]
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // sequencer registers
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_r    <= ST_IDLE;
            par_r      <= '0;
            fetchIdx_r <= 8'h00;
            fetchNum_r <= 2'd0;
            row_r      <= 2'd0;
            halfCnt_r  <= 10'h000;
            remCnt_r   <= 10'h000;
            newHalf_r  <= 1'b0;
            lowTone_r  <= 1'b0;
            err_r      <= 1'b0;
            reload_r   <= '0;
        end else begin
            state_r    <= state_nxt;
            par_r      <= par_nxt;
            fetchIdx_r <= fetchIdx_nxt;
            fetchNum_r <= fetchNum_nxt;
            row_r      <= row_nxt;
            halfCnt_r  <= halfCnt_nxt;
            remCnt_r   <= remCnt_nxt;
            newHalf_r  <= newHalf_nxt;
            lowTone_r  <= lowTone_nxt;
            err_r      <= err_nxt;
            reload_r   <= reload_nxt;
        end
    end

    // register port: timer control write and read mux
    always_comb begin
        ctrl_nxt   = ctrl_r;
        rdData_nxt = 8'h00;
        if (regWrStrobe && regAddr == REG_TIMER_CTRL) begin
            ctrl_nxt = regWrData;                              // [R16]
        end
        // the sequencer outranks a software write in the same cycle
        if (hbPreset) begin
            ctrl_nxt = CTRL_START;                             // [R16]
        end else if (hbClear) begin
            ctrl_nxt = CTRL_RESET;                             // [R07]
        end
        if (regRdStrobe) begin
            if (regAddr == REG_STATUS) begin
                rdData_nxt[STAT_LOW_BIT]  = lowTone_r;
                rdData_nxt[STAT_HIGH_BIT] = highTone;
                rdData_nxt[STAT_ERR_BIT]  = err_r;
                rdData_nxt[STAT_BUSY_BIT] = busy;
            end else if (regAddr == REG_TIMER_CTRL) begin
                rdData_nxt = ctrl_r;
            end else if (regAddr >= TABLE_BASE && regAddr <= TABLE_LAST) begin
                rdData_nxt = tableRead(regAddr);               // [R03]
            end else begin
                rdData_nxt = 8'h00;                            // unmapped reads zero
            end
        end
    end

    // register port state
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ctrl_r   <= CTRL_RESET;
            rdData_r <= 8'h00;
        end else begin
            ctrl_r   <= ctrl_nxt;
            rdData_r <= rdData_nxt;
        end
    end

    // high-band timer; runs only while the mode and run bits are set
    hb_toggle_timer #(
        .W (TW)
    ) u_hb_timer (
        .clock     (clock),
        .rstn      (rstn),
        .preset    (hbPreset),
        .clear     (hbClear),
        .run       (ctrl_r[CTRL_RUN_BIT] && ctrl_r[CTRL_MODE_BIT]), // [R13]
        .toggleEn  (ctrl_r[CTRL_TOGGLE_BIT]),
        .reloadVal (reload_r),
        .toneOut   (highTone),
        .count     (hbCount)
    );

    assign lowToneOut  = lowTone_r;
    assign highToneOut = highTone;
    assign busy        = (state_r != ST_IDLE) && (state_r != ST_DONE); // [R20]
    assign done        = (state_r == ST_DONE);                 // [R20]
    assign keyError    = err_r;
    assign regRdData   = rdData_r;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    sequence badKeyStart;
        state_r == ST_IDLE && startPulse && keyMatrix[7:4] != KEY_VALID;
    endsequence

    chk_bad_key: assert property (  // [R17]
        badKeyStart |=> keyError && done && !lowToneOut && !highToneOut ##1 !busy)
        else $error("bad key did not end with error flag");

    chk_fetch_order: assert property (  // [R18]
        (state_r == ST_FETCH && fetchNum_r == 2'd2) |=>
            par_r.quot == PARAM_TABLE[{row_r, 2'b10}] && state_r == ST_HALF)
        else $error("quotient not fetched before low-band start");

    chk_low_toggle: assert property (  // [R05]
        (state_r == ST_HALF && $changed(lowToneOut)) |-> $past(halfCnt_r) == 10'h000)
        else $error("low tone changed without half-period expiry");

    chk_half_reload: assert property (  // [R10]
        (state_r == ST_HALF && $changed(lowToneOut)) |-> halfCnt_r == par_r.halfTotal - 10'h001)
        else $error("half-period counter not reloaded");

    chk_quot_step: assert property (  // [R06]
        (state_r == ST_HALF && newHalf_r && par_r.quot > 8'h01) |=> par_r.quot == $past(par_r.quot) - 8'h01)
        else $error("quotient not decremented once per half period");

    chk_rem_entry: assert property (  // [R06]
        (state_r == ST_HALF && newHalf_r && par_r.quot == 8'h01) |=>
            state_r == ST_REM && $stable(lowToneOut))
        else $error("quotient expiry did not enter remainder");

    chk_burst_end: assert property (  // [R07]
        (state_r == ST_REM && remCnt_r == 10'h000) |=> !lowToneOut && !highToneOut && done ##1 !done)
        else $error("burst end did not clear both tones");

    chk_ctrl_start: assert property (  // [R16]
        (state_r == ST_FETCH && fetchNum_r == 2'd2) |=> ctrl_r == CTRL_START && hbCount == HB_PRESET[TW-1:0])
        else $error("timer not started with control value at burst start");
endmodule
`default_nettype wire

// ---- core/tone_pkg.sv ----
// shared constants and types for the square-wave dual-tone generator
package tone_pkg;
    // register offsets on the plain register port
    localparam logic [7:0] REG_STATUS     = 8'h00;    // busy, error, tone levels
    localparam logic [7:0] REG_TIMER_CTRL = 8'hff;    // high-band timer control
    localparam logic [7:0] TABLE_BASE     = 8'h30;    // first parameter entry
    localparam logic [7:0] TABLE_LAST     = 8'h3f;    // last parameter entry
    // timer control fields
    localparam int CTRL_MODE_BIT   = 7;               // toggle-output timer mode
    localparam int CTRL_TOGGLE_BIT = 5;               // output enable
    localparam int CTRL_RUN_BIT    = 4;               // counter running
    localparam logic [7:0] CTRL_START = 8'hb0;        // value loaded at burst start
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // status fields
    localparam int STAT_LOW_BIT  = 0;
    localparam int STAT_HIGH_BIT = 1;
    localparam int STAT_ERR_BIT  = 2;
    localparam int STAT_BUSY_BIT = 3;
    // key code layout and validity pattern
    localparam logic [3:0] KEY_VALID  = 4'h9;         // upper nibble of a single key
    localparam logic [3:0] VEC_PREFIX = 4'h3;         // upper nibble of every index
    localparam logic [1:0] SUB_TIMER  = 2'h0;
    localparam logic [1:0] SUB_HALF   = 2'h3;
    // timing
    localparam int        CLOCK_MHZ    = 100;
    localparam int        BURST_CYCLES = 35796;       // nominal burst length in cycles
    localparam int        UNIT_CYCLES  = 6;           // one stall unit
    localparam logic [5:0] REM_OVERHEAD = 6'h14;      // fixed remainder cycles (20)
    localparam logic [7:0] HB_PRESET   = 8'h0f;       // high-band first count (15)
    // per-row half-period overhead: 35, 40, 30, 40 cycles
    localparam logic [5:0] HALF_OVERHEAD [0:3] = '{6'h23, 6'h28, 6'h1e, 6'h28};
    // sixteen parameter entries at indices 0x30..0x3f
    localparam logic [7:0] PARAM_TABLE [0:15] = '{
        8'h93, 8'h0a, 8'h8c, 8'h26,
        8'h85, 8'h09, 8'h9b, 8'h21,
        8'h78, 8'h0e, 8'hab, 8'h1f,
        8'h6d, 8'h0a, 8'hbd, 8'h1a};
    // burst controller states
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_FETCH = 3'b001,
        ST_HALF  = 3'b010,
        ST_REM   = 3'b011,
        ST_DONE  = 3'b100
    } state_t;
    // low-band parameters after conversion to cycles
    typedef struct packed {
        logic [9:0] halfTotal;    // cycles per low-band half period
        logic [7:0] quot;         // half periods plus one
        logic [9:0] remTotal;     // cycles of the remainder phase
    } tone_params_t;
endpackage

// ---- dv/keypad_scanner_model.sv ----
// keypad scanner model: turns active-low row and column nibbles into a start request
`timescale 1ns/1ns
`default_nettype none
module keypad_scanner_model (
    input  wire logic       clock,
    input  wire logic       rstn,
    input  wire logic       req,         // bench asks for one key press
    input  wire logic [3:0] rowN,        // active-low row nibble
    input  wire logic [3:0] colN,        // active-low column nibble
    output logic            startPulse,  // one-cycle burst request
    output logic [7:0]      keyMatrix    // digit matrix vector
);
    logic [2:0] rowDec;  // bit 2 marks a single key, 1:0 its index
    logic [2:0] colDec;
    // only one low bit in a nibble is a single key
    function automatic logic [2:0] decode(input logic [3:0] n);
        case (n)
            4'he: decode = 3'b100;
            4'hd: decode = 3'b101;
            4'hb: decode = 3'b110;
            4'h7: decode = 3'b111;
            default: decode = 3'b000;  // no key or several keys
        endcase
    endfunction
    assign rowDec = decode(rowN);
    assign colDec = decode(colN);
    // vector is only meaningful beside the pulse, so it is scrambled in between
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            startPulse <= 1'b0;
            keyMatrix  <= 8'h00;
        end else begin
            startPulse <= req;
            keyMatrix  <= req ? {rowDec[2], 2'b00, colDec[2], rowDec[1:0], colDec[1:0]} : ~keyMatrix;
        end
    end
endmodule
`default_nettype wire

// ---- dv/tb.sv ----
// self-checking bench for the square-wave dual-tone burst generator
`timescale 1ns/1ns
`default_nettype none
module tb;
    import tone_pkg::*;
    logic       clock = 1'b0;        // 100 MHz
    logic       rstn = 1'b0;         // async, active low
    logic       req = 1'b0;          // key press request to the scanner
    logic [3:0] rowN = 4'hf;         // active-low row nibble
    logic [3:0] colN = 4'hf;         // active-low column nibble
    logic       startPulse;
    logic [7:0] keyMatrix;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWrData = 8'h00;
    logic       regWrStrobe = 1'b0;
    logic       regRdStrobe = 1'b0;
    logic [7:0] regRdData;
    logic       lowToneOut;
    logic       highToneOut;
    logic       busy;
    logic       done;
    logic       keyError;
    logic [7:0] d;                   // last read data
    int         badCount = 0;
    int         comparisons = 0;
    int         cycles = 0;          // hang guard
    // per row: half period, stored quotient, remainder cycles; per column: high half period
    localparam int HALF [0:3] = '{257, 232, 210, 190};
    localparam int QST  [0:3] = '{140, 155, 171, 189};
    localparam int REMC [0:3] = '{74, 68, 98, 74};
    localparam int HBH  [0:3] = '{148, 134, 121, 110};
    // register read rows: address beside expected data after reset
    typedef struct packed { logic [7:0] addr; logic [7:0] data; } rd_row_t;
    localparam rd_row_t ROWS [0:19] = '{'{8'h30, 8'h93}, '{8'h31, 8'h0a}, '{8'h32, 8'h8c}, '{8'h33, 8'h26},
        '{8'h34, 8'h85}, '{8'h35, 8'h09}, '{8'h36, 8'h9b}, '{8'h37, 8'h21}, '{8'h38, 8'h78}, '{8'h39, 8'h0e},
        '{8'h3a, 8'hab}, '{8'h3b, 8'h1f}, '{8'h3c, 8'h6d}, '{8'h3d, 8'h0a}, '{8'h3e, 8'hbd}, '{8'h3f, 8'h1a},
        '{8'h00, 8'h00}, '{8'hff, 8'h00}, '{8'h2f, 8'h00}, '{8'h40, 8'h00}};

    square_tone_routine u_square_tone_routine (.clock(clock), .rstn(rstn), .startPulse(startPulse),
        .keyMatrix(keyMatrix), .regAddr(regAddr), .regWrData(regWrData), .regWrStrobe(regWrStrobe),
        .regRdStrobe(regRdStrobe), .regRdData(regRdData), .lowToneOut(lowToneOut),
        .highToneOut(highToneOut), .busy(busy), .done(done), .keyError(keyError));
    keypad_scanner_model u_keypad_scanner_model (.clock(clock), .rstn(rstn), .req(req), .rowN(rowN),
        .colN(colN), .startPulse(startPulse), .keyMatrix(keyMatrix));

    always #5 clock = ~clock;

    // verdict and end of run, also reached by the hang guard
    task automatic reportAndStop();
        if (badCount == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // compare with case equality so unknowns never match
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        comparisons++;
        if (seen !== want) begin
            badCount++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    // bus tasks are entered right after a rising edge
    task automatic regWrite(input logic [7:0] a, input logic [7:0] wd);
        regAddr     <= a;
        regWrData   <= wd;
        regWrStrobe <= 1'b1;
        @(posedge clock);
        regWrStrobe <= 1'b0;
    endtask
    task automatic regRead(input logic [7:0] a, output logic [7:0] rd);
        regAddr     <= a;
        regRdStrobe <= 1'b1;
        @(posedge clock);
        regRdStrobe <= 1'b0;
        @(posedge clock);
        rd = regRdData;
    endtask
    // one burst for a key; a partial one is cut by a reset in mid-run
    task automatic burst(input int r, input int c, input bit full);
        int n = 0;
        int firstLow = 0;
        int firstHigh = 0;
        int secondHigh = 0;
        int lowCount = 0;
        logic lp = 1'b0;
        logic hp = 1'b0;
        rowN <= ~(4'h1 << r);
        colN <= ~(4'h1 << c);
        req  <= 1'b1;
        @(posedge clock);
        req <= 1'b0;
        @(posedge clock);  // design takes the start here
        while (n < 40000 && (full || n < 600)) begin
            @(posedge clock);
            n++;
            // a bad key offered while busy must be ignored
            if (n == 98) begin
                rowN <= 4'h0;
                req  <= 1'b1;
            end
            if (n == 99)
                req <= 1'b0;
            #1;
            if (n == 1)
                check({busy, keyError}, 2'b10);
            if (busy !== 1'b1)
                break;
            if (lowToneOut !== lp) begin
                lowCount++;
                if (firstLow == 0)
                    firstLow = n;
            end
            if (highToneOut !== hp && firstHigh != 0 && secondHigh == 0)
                secondHigh = n;
            if (highToneOut !== hp && firstHigh == 0)
                firstHigh = n;
            lp = lowToneOut;
            hp = highToneOut;
        end
        check(firstLow, 3 + HALF[r]);
        check(firstHigh, 19);
        check(secondHigh - firstHigh, HBH[c]);
        if (full) begin
            check(n, 4 + (QST[r] - 1) * HALF[r] + REMC[r]);
            check(lowCount, QST[r] - 1);
            check({done, lowToneOut, highToneOut, keyError}, 4'b1000);
            @(posedge clock);
            #1;
            check(done, 1'b0);
            regRead(REG_TIMER_CTRL, d);
            check(d, CTRL_RESET);
        end else begin
            regRead(REG_TIMER_CTRL, d);
            check(d, CTRL_START);
            regWrite(REG_TIMER_CTRL, CTRL_START);
            regRead(REG_STATUS, d);
            check(d[STAT_BUSY_BIT], 1'b1);
            rstn <= 1'b0;
            #1;
            check({busy, done, keyError, lowToneOut, highToneOut}, 5'h00);
            @(posedge clock);
            rstn <= 1'b1;
        end
    endtask

    // hang guard: two full bursts take about 72000 cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles == 90000) begin
            badCount++;
            reportAndStop();
        end
    end

    initial begin
        repeat (2) @(posedge clock);
        #1;
        check({busy, done, keyError, lowToneOut, highToneOut, regRdData}, 13'h0000);
        @(posedge clock);
        rstn <= 1'b1;
        @(posedge clock);
        // reset values, parameter table and unmapped places
        foreach (ROWS[i]) begin
            regRead(ROWS[i].addr, d);
            check(d, ROWS[i].data);
        end
        // the table refuses writes
        regWrite(8'h31, 8'h55);
        regRead(8'h31, d);
        check(d, 8'h0a);
        // two rows pressed at once: error, done, no tones
        rowN <= 4'hc;
        colN <= 4'he;
        req  <= 1'b1;
        @(posedge clock);
        req <= 1'b0;
        @(posedge clock);  // design takes the bad start here
        #1;
        check({done, keyError, busy}, 3'b110);
        @(posedge clock);
        #1;
        check({done, keyError, lowToneOut, highToneOut}, 4'b0100);
        @(posedge clock);
        // every row and column once, rows and columns crossed
        burst(0, 3, 1'b1);
        burst(1, 2, 1'b0);
        burst(2, 1, 1'b0);
        burst(3, 0, 1'b1);
        reportAndStop();
    end
endmodule
`default_nettype wire
